// ---- design/isc_pkg.sv ----
package isc_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ISC_ADDR_CTRL = 8'h2c;
  localparam logic [7:0] ISC_RESET_CTRL = 8'h00;
  localparam logic [7:0] ISC_READ_ZERO = 8'h00;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int ISC_BIT_GATE = 7;
  localparam int ISC_BIT_WAKE_TRANS = 6;
  localparam int ISC_BIT_WAKE_ORIENT = 5;
  localparam int ISC_BIT_WAKE_PULSE = 4;
  localparam int ISC_BIT_WAKE_FFMT = 3;
  localparam int ISC_BIT_WAKE_VECM = 2;
  localparam int ISC_BIT_POL = 1;
  localparam int ISC_BIT_DRIVE = 0;
  localparam int ISC_NUM_FUNC = 5;
  localparam int ISC_WAKE_LSB = 2;

  // ----------------------------------------------------------------
  // Gate state machine
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ISC_GATE_OPEN = 3'h1,
    ISC_GATE_HOLD = 3'h2,
    ISC_GATE_ERR = 3'h4
  } isc_gate_t;
endpackage : isc_pkg

// ---- design/isc_irq_pin.sv ----
`timescale 1ns/1ps
`default_nettype none
// Drives one interrupt pin from its combined request, polarity and drive style.
module isc_irq_pin
  import isc_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Control
  input wire logic req_in,
  input wire logic active_high_in,
  input wire logic open_drain_in,
  // Pin
  output logic pin_out,
  output logic pin_oe_out
);
  logic level;

  // ----------------------------------------------------------------
  // Pin driver
  // ----------------------------------------------------------------
  // Asserted level follows the polarity select.
  assign level = active_high_in ? req_in : ~req_in;

  // Open drain only drives while the line is low; the pull-up gives the high.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pin_out <= 1'b1;
      pin_oe_out <= 1'b1;
    end else begin
      pin_out <= level;
      pin_oe_out <= open_drain_in ? ~level : 1'b1;
    end
  end
endmodule : isc_irq_pin
`default_nettype wire

// ---- design/isc_fifo_gate.sv ----
`timescale 1ns/1ps
`default_nettype none
// Decides flushing and sample acceptance for the sample FIFO across mode changes.
module isc_fifo_gate
  import isc_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Control
  input wire logic gate_en_in,
  input wire logic mode_change_in,
  input wire logic rate_change_in,
  input wire logic sample_in,
  input wire logic fifo_empty_in,
  // Results
  output logic flush_out,
  output logic accept_out,
  output logic gate_err_out
);
  isc_gate_t state;
  isc_gate_t next_state;

  // ----------------------------------------------------------------
  // Combinational decisions
  // ----------------------------------------------------------------
  // A rate change always flushes, so a gate hold is dropped then too.
  always_comb begin
    next_state = state;
    flush_out = 1'b0;
    accept_out = 1'b0;
    case (state)
      ISC_GATE_OPEN: begin
        accept_out = sample_in;
        if (mode_change_in && gate_en_in && !fifo_empty_in) begin
          next_state = ISC_GATE_HOLD;
          accept_out = 1'b0;
        end
      end
      ISC_GATE_HOLD: begin
        if (fifo_empty_in) begin
          next_state = ISC_GATE_OPEN;
        end else if (sample_in) begin
          next_state = ISC_GATE_ERR;
        end
      end
      ISC_GATE_ERR: begin
        if (fifo_empty_in) begin
          next_state = ISC_GATE_OPEN;
        end
      end
      default: begin
        next_state = ISC_GATE_OPEN;
      end
    endcase
    // With the gate off every mode change flushes, even if the gate bit was cleared during a hold.
    if (mode_change_in && !gate_en_in) begin
      flush_out = 1'b1;
      accept_out = 1'b0;
      next_state = ISC_GATE_OPEN;
    end
    if (rate_change_in) begin
      flush_out = 1'b1;
      accept_out = 1'b0;
      next_state = ISC_GATE_OPEN;
    end
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state <= ISC_GATE_OPEN;
    end else begin
      state <= next_state;
    end
  end

  assign gate_err_out = (state == ISC_GATE_ERR);
endmodule : isc_fifo_gate
`default_nettype wire

// ---- design/isc_top.sv ----
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Gate clear: every sleep/wake change flushes the FIFO.
// - Gate set: mode change keeps FIFO contents, new samples dropped until emptied.
// - Gate set: sample arriving before FIFO emptied sets gate-error status.
// - Gate error holds while FIFO unemptied and no flush occurs; host clears it by draining FIFO.
// - Bit 6 keeps transient detection running and waking in sleep.
// - Bit 5 keeps orientation detection running and waking in sleep.
// - Bit 4 keeps pulse detection running and waking in sleep.
// - Bit 3 keeps freefall/motion detection running and waking in sleep.
// - Bit 2 keeps vector-magnitude detection running and waking in sleep.
// - Bit 1 selects interrupt pin polarity, 0 active low, 1 active high.
// - Bit 0 selects interrupt pin drive, 0 push-pull, 1 open drain.
// - Any output sample rate change flushes the FIFO.
// - With auto-sleep, each mode change resets debounce counters, keeps status.
// - All sources routed to one pin are ORed together.
module isc_top
  import isc_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Register port
  input wire logic [7:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  // System mode and sample path
  input wire logic sleep_mode_in,
  input wire logic auto_sleep_en_in,
  input wire logic rate_change_in,
  input wire logic sample_in,
  input wire logic fifo_empty_in,
  output logic fifo_flush_out,
  output logic fifo_accept_out,
  output logic gate_err_out,
  output logic debounce_reset_out,
  // Event functions
  input wire logic [4:0] func_event_in,
  input wire logic [4:0] func_route_a_in,
  output logic [4:0] func_run_out,
  output logic wake_request_out,
  // Interrupt pins
  input wire logic [4:0] other_irq_a_in,
  input wire logic [4:0] other_irq_b_in,
  output logic irq_pin_a_out,
  output logic irq_pin_a_oe_out,
  output logic irq_pin_b_out,
  output logic irq_pin_b_oe_out
);
  logic [7:0] interrupt_sleep_control;
  logic sleep_d;
  logic mode_change;
  logic flush;
  logic accept;
  logic gate_err;
  logic [4:0] wake_en;
  logic [4:0] func_live;
  logic [4:0] route_a_hits;
  logic [4:0] route_b_hits;
  logic req_a;
  logic req_b;

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  // All eight bits are plain read/write storage.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      interrupt_sleep_control <= ISC_RESET_CTRL;
    end else if (reg_wr_in && reg_addr_in == ISC_ADDR_CTRL) begin
      interrupt_sleep_control <= reg_wdata_in;
    end
  end

  // Read data is registered; other addresses belong to other blocks and read zero here.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      reg_rdata_out <= ISC_READ_ZERO;
    end else if (reg_rd_in && reg_addr_in == ISC_ADDR_CTRL) begin
      reg_rdata_out <= interrupt_sleep_control;
    end else begin
      reg_rdata_out <= ISC_READ_ZERO;
    end
  end

  // ----------------------------------------------------------------
  // Mode change detection
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sleep_d <= 1'b0;
    end else begin
      sleep_d <= sleep_mode_in;
    end
  end

  assign mode_change = sleep_mode_in ^ sleep_d;

  // ----------------------------------------------------------------
  // FIFO gate
  // ----------------------------------------------------------------
  isc_fifo_gate u_gate (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .gate_en_in(interrupt_sleep_control[ISC_BIT_GATE]),
    .mode_change_in(mode_change),
    .rate_change_in(rate_change_in),
    .sample_in(sample_in),
    .fifo_empty_in(fifo_empty_in),
    .flush_out(flush),
    .accept_out(accept),
    .gate_err_out(gate_err)
  );

  // Outputs are registered, so flush and accept lag their cause by one cycle.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      fifo_flush_out <= 1'b0;
      fifo_accept_out <= 1'b0;
      gate_err_out <= 1'b0;
      debounce_reset_out <= 1'b0;
    end else begin
      fifo_flush_out <= flush;
      fifo_accept_out <= accept;
      gate_err_out <= gate_err;
      // Status is kept elsewhere; only the debounce counters are told to restart.
      debounce_reset_out <= mode_change & auto_sleep_en_in;
    end
  end

  // ----------------------------------------------------------------
  // Sleep wake sources
  // ----------------------------------------------------------------
  // Index 4 transient, 3 orientation, 2 pulse, 1 freefall/motion, 0 vector magnitude.
  assign wake_en = interrupt_sleep_control[ISC_WAKE_LSB +: ISC_NUM_FUNC];

  // In wake mode every function runs; in sleep only those enabled for wake.
  generate
    for (genvar i = 0; i < ISC_NUM_FUNC; i++) begin : g_func
      assign func_live[i] = ~sleep_mode_in | wake_en[i];
    end
  endgenerate

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      func_run_out <= 5'h1f;
      wake_request_out <= 1'b0;
    end else begin
      func_run_out <= func_live;
      wake_request_out <= sleep_mode_in & |(func_event_in & wake_en);
    end
  end

  // ----------------------------------------------------------------
  // Interrupt combining
  // ----------------------------------------------------------------
  // A function that is stopped in sleep cannot raise its pin either.
  assign route_a_hits = func_event_in & func_live & func_route_a_in;
  assign route_b_hits = func_event_in & func_live & ~func_route_a_in;
  assign req_a = |route_a_hits | |other_irq_a_in;
  assign req_b = |route_b_hits | |other_irq_b_in;

  isc_irq_pin u_pin_a (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .req_in(req_a),
    .active_high_in(interrupt_sleep_control[ISC_BIT_POL]),
    .open_drain_in(interrupt_sleep_control[ISC_BIT_DRIVE]),
    .pin_out(irq_pin_a_out),
    .pin_oe_out(irq_pin_a_oe_out)
  );

  isc_irq_pin u_pin_b (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .req_in(req_b),
    .active_high_in(interrupt_sleep_control[ISC_BIT_POL]),
    .open_drain_in(interrupt_sleep_control[ISC_BIT_DRIVE]),
    .pin_out(irq_pin_b_out),
    .pin_oe_out(irq_pin_b_oe_out)
  );
endmodule : isc_top
`default_nettype wire

// ---- dv/isc_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none
// Port-level checker; keeps its own copy of the control byte from the writes it sees.
module isc_asserts
  import isc_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Register port
  input wire logic [7:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic [7:0] reg_rdata_out,
  // Sample path
  input wire logic sleep_mode_in,
  input wire logic rate_change_in,
  input wire logic sample_in,
  input wire logic fifo_empty_in,
  input wire logic fifo_flush_out,
  input wire logic fifo_accept_out,
  input wire logic gate_err_out,
  // Functions and pins
  input wire logic [4:0] func_event_in,
  input wire logic [4:0] func_route_a_in,
  input wire logic [4:0] func_run_out,
  input wire logic wake_request_out,
  input wire logic [4:0] other_irq_a_in,
  input wire logic irq_pin_a_out,
  input wire logic irq_pin_b_out,
  input wire logic irq_pin_b_oe_out
);
  logic [7:0] ctrl;
  logic [4:0] run_c;
  logic req_a;
  // Shadow copy; only a write at the control address moves it.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in)
      ctrl <= 8'h00;
    else if (reg_wr_in && reg_addr_in == ISC_ADDR_CTRL)
      ctrl <= reg_wdata_in;
  end
  // Stopped functions must not reach a pin, so the mask is part of the request.
  assign run_c = sleep_mode_in ? ctrl[6:2] : 5'h1f;
  assign req_a = (|(func_event_in & func_route_a_in & run_c)) | (|other_irq_a_in);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  a_read_back: assert property (
    reg_rd_in && reg_addr_in == ISC_ADDR_CTRL |=> reg_rdata_out == $past(ctrl))
    else $error("read data differs from control byte");
  a_flush_mode: assert property (
    !ctrl[7] && $changed(sleep_mode_in) |=> fifo_flush_out) else $error("no flush on mode change");
  a_flush_rate: assert property (
    rate_change_in |=> fifo_flush_out) else $error("no flush on rate change");
  // The status output trails the gate state by one edge, so the state's own cause is one edge back.
  a_err_holds: assert property (
    gate_err_out && !$past(fifo_empty_in) && !$past(rate_change_in) |=> gate_err_out)
    else $error("gate error dropped");
  a_err_clear: assert property (
    gate_err_out && fifo_empty_in |=> ##1 !gate_err_out) else $error("gate error not cleared");
  a_gate_drop: assert property (
    gate_err_out && sample_in && !$past(fifo_empty_in) && !$past(rate_change_in) |=> !fifo_accept_out)
    else $error("sample accepted while gated");
  a_run_mask: assert property (
    1'b1 |=> func_run_out == $past(run_c)) else $error("function run mask wrong");
  a_wake_req: assert property (
    1'b1 |=> wake_request_out == $past(sleep_mode_in && |(func_event_in & ctrl[6:2])))
    else $error("wake request wrong");
  a_pin_level: assert property (
    1'b1 |=> irq_pin_a_out == ($past(ctrl[1]) ~^ $past(req_a))) else $error("pin a level wrong");
  a_pin_drive: assert property (
    1'b1 |=> irq_pin_b_oe_out == ($past(ctrl[0]) ? !irq_pin_b_out : 1'b1))
    else $error("pin b enable wrong");
endmodule // isc_asserts
bind isc_top isc_asserts i_isc_asserts (.*);
`default_nettype wire

// ---- dv/isc_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// Host side of the register port; one strobe cycle per access, changed on falling edges.
module isc_host_model (
  // Clock
  input wire logic clk_in,
  // Register port
  output logic [7:0] reg_addr_out,
  output logic reg_wr_out,
  output logic reg_rd_out,
  output logic [7:0] reg_wdata_out
);
  // Idle bus starts quiet at time zero.
  initial begin
    reg_addr_out = 8'h00;
    reg_wr_out = 1'b0;
    reg_rd_out = 1'b0;
    reg_wdata_out = 8'h00;
  end
  // Released lines show the inverse so a stale value is never mistaken for live data.
  task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_in);
    reg_addr_out = a;
    reg_wdata_out = d;
    reg_wr_out = w;
    reg_rd_out = !w;
    @(negedge clk_in);
    reg_wr_out = 1'b0;
    reg_rd_out = 1'b0;
    reg_addr_out = ~a;
    reg_wdata_out = ~d;
  endtask
endmodule // isc_host_model
`default_nettype wire

// ---- dv/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import isc_pkg::*;
;
  logic clk_in = 1'b0;
  logic rst_n_in, reg_wr_in, reg_rd_in, sleep_mode_in, auto_sleep_en_in, rate_change_in;
  logic sample_in, fifo_empty_in, fifo_flush_out, fifo_accept_out, gate_err_out, debounce_reset_out;
  logic wake_request_out, irq_pin_a_out, irq_pin_a_oe_out, irq_pin_b_out, irq_pin_b_oe_out, rd_q;
  logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out, seed;
  logic [4:0] func_event_in, func_route_a_in, func_run_out, other_irq_a_in, other_irq_b_in;
  logic [7:0] exp_q[$];
  int n_fail = 0;
  int comparisons = 0;
  logic lvl;
  isc_top i_dut (.*);
  isc_host_model i_host (.clk_in(clk_in), .reg_addr_out(reg_addr_in), .reg_wr_out(reg_wr_in),
    .reg_rd_out(reg_rd_in), .reg_wdata_out(reg_wdata_in));
  // Free-running 100 MHz clock.
  always #5 clk_in = ~clk_in;
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    i_host.access(1'b0, a, 8'h00);
  endtask
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Read data lands one cycle after its strobe; pair it with the oldest note.
  always @(posedge clk_in) rd_q <= reg_rd_in;
  always @(negedge clk_in) if (rd_q === 1'b1) chk("rdata", exp_q.pop_front(), reg_rdata_out);
  // Whole run needs about 90 cycles, so this limit only trips on a hang.
  initial begin
    #20000;
    n_fail++;
    test_done();
  end
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  initial begin
    {sleep_mode_in, auto_sleep_en_in, rate_change_in, sample_in} = 4'h0;
    {func_event_in, func_route_a_in, other_irq_a_in, other_irq_b_in} = 20'h0;
    fifo_empty_in = 1'b1;
    seed = 8'h48;
    rst_n_in = 1'b0;
    repeat (2) @(negedge clk_in);
    rst_n_in = 1'b1;
    chk("pin_a", 8'h01, {7'h0, irq_pin_a_out & irq_pin_a_oe_out});
    rd(ISC_ADDR_CTRL, ISC_RESET_CTRL);
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      i_host.access(1'b1, ISC_ADDR_CTRL, seed);
      i_host.access(1'b1, 8'h2d, ~seed);
      rd(ISC_ADDR_CTRL, seed);
      rd(8'h2d, ISC_READ_ZERO);
    end
    $display("registers done");
    i_host.access(1'b1, ISC_ADDR_CTRL, 8'h00);
    fifo_empty_in = 1'b0;
    sleep_mode_in = 1'b1;
    @(negedge clk_in);
    chk("flush", 8'h01, {7'h0, fifo_flush_out});
    sample_in = 1'b1;
    @(negedge clk_in);
    chk("accept", 8'h01, {7'h0, fifo_accept_out});
    sample_in = 1'b0;
    rate_change_in = 1'b1;
    @(negedge clk_in);
    chk("flush", 8'h01, {7'h0, fifo_flush_out});
    rate_change_in = 1'b0;
    sleep_mode_in = 1'b0;
    @(negedge clk_in);
    chk("flush", 8'h01, {7'h0, fifo_flush_out});
    $display("flush done");
    i_host.access(1'b1, ISC_ADDR_CTRL, 8'h80);
    auto_sleep_en_in = 1'b1;
    sleep_mode_in = 1'b1;
    @(negedge clk_in);
    chk("flush", 8'h00, {7'h0, fifo_flush_out});
    chk("debounce", 8'h01, {7'h0, debounce_reset_out});
    sample_in = 1'b1;
    @(negedge clk_in);
    chk("accept", 8'h00, {7'h0, fifo_accept_out});
    // The error shows one edge after the gate state takes it, two after the sample.
    @(negedge clk_in);
    chk("err", 8'h01, {7'h0, gate_err_out});
    sample_in = 1'b0;
    repeat (3) @(negedge clk_in);
    chk("err", 8'h01, {7'h0, gate_err_out});
    fifo_empty_in = 1'b1;
    repeat (2) @(negedge clk_in);
    chk("err", 8'h00, {7'h0, gate_err_out});
    {auto_sleep_en_in, sleep_mode_in} = 2'h0;
    $display("gate done");
    for (int i = 0; i < 5; i++) begin
      i_host.access(1'b1, ISC_ADDR_CTRL, 8'h04 << i);
      sleep_mode_in = 1'b1;
      func_event_in = 5'h1f;
      @(negedge clk_in);
      chk("run", 8'h01 << i, {3'h0, func_run_out});
      chk("wake", 8'h01, {7'h0, wake_request_out});
      func_event_in = ~(5'h01 << i);
      @(negedge clk_in);
      chk("wake", 8'h00, {7'h0, wake_request_out});
      {sleep_mode_in, func_event_in} = 6'h0;
    end
    $display("wake done");
    for (int c = 0; c < 4; c++) begin
      i_host.access(1'b1, ISC_ADDR_CTRL, 8'(c));
      for (int r = 0; r < 2; r++) begin
        // Each pin alternately gets its request from a function or from another source only.
        func_event_in = 5'(r * 8);
        func_route_a_in = c[0] ? 5'h08 : 5'h00;
        other_irq_a_in = c[0] ? 5'h00 : 5'(r * 2);
        other_irq_b_in = c[0] ? 5'(r) : 5'h00;
        @(negedge clk_in);
        lvl = c[1] ~^ r[0];
        chk("pin_a", {7'h0, lvl}, {7'h0, irq_pin_a_out});
        chk("pin_b", {7'h0, lvl}, {7'h0, irq_pin_b_out});
        chk("oe_a", {7'h0, c[0] ? !lvl : 1'b1}, {7'h0, irq_pin_a_oe_out});
        chk("oe_b", {7'h0, c[0] ? !lvl : 1'b1}, {7'h0, irq_pin_b_oe_out});
      end
    end
    $display("pins done");
    test_done();
  end
endmodule // tb_top
`default_nettype wire
